// File: hw/parity_chk_pkg.sv
// Package: constants and types for the cache data RAM parity checker
package parity_chk_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] AUX_CTRL_OFS   = 8'h00;
    localparam logic [7:0] LAT_CTRL_OFS   = 8'h04;
    localparam logic [7:0] RAW_INT_OFS    = 8'h08;
    localparam logic [7:0] MASKED_INT_OFS = 8'h0C;
    localparam logic [7:0] INT_MASK_OFS   = 8'h10;
    localparam logic [7:0] INT_CLEAR_OFS  = 8'h14;
    localparam logic [7:0] ERR_COUNT_OFS  = 8'h18;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int          PARITY_EN_BIT   = 21;
    localparam int          RD_LAT_LSB      = 4;
    localparam int          RD_LAT_W        = 3;
    localparam int          PERR_BIT        = 0;
    localparam int          FAIL_LSB        = 6;
    localparam logic [31:0] AUX_CTRL_RST    = 32'h0000_0000;
    localparam logic [2:0]  RD_LAT_RST      = 3'h0;
    localparam logic        INT_MASK_RST    = 1'b0;

    // ************************************************************
    // Data widths
    // ************************************************************
    localparam int WORD_W  = 256;
    localparam int PAR_W   = 32;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Read port of the data RAM, as seen by the checker
    typedef struct packed {
        logic              rd_req;
        logic [WORD_W-1:0] data_ram_read_word;
        logic [PAR_W-1:0]  stored_parity_word;
    } ram_read_t;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_WAIT,
        RD_CHECK
    } rd_state_t;

endpackage

// File: hw/l2_data_ram_parity_checker.sv
// Parity checker for the level-2 cache data RAM, with AXI4-Lite registers
// Contract
// RQ1: Each data RAM read checks the 256-bit word against 32 parity bits; a read requested in RD_WAIT goes unchecked.
// RQ2: A mismatch sets a raw status bit, also shown in a masked status.
// RQ3: Checking and reporting happen only while parity enable bit 21 is 1.
// RQ4: The parity enable bit reads 0 after reset.
// RQ5: Latency bits 6:4 give added read wait cycles, zero meaning none.
// RQ6: With latency, parity is evaluated only in the one cycle data is valid.
// RQ7: Two parity-fail outputs at bits 7:6 rise on a data parity error.
// RQ8: Each stored parity bit covers one byte lane; any lane mismatch errs.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
module l2_data_ram_parity_checker
    import parity_chk_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        clk_en,
    // Data RAM read port
    input  wire parity_chk_pkg::ram_read_t   ram_rd,
    // Fault indications
    output logic [7:0]                       parity_fail_flags,
    output logic                             irq,
    // AXI4-Lite slave
    input  wire logic [7:0]                  s_awaddr,
    input  wire logic                        s_awvalid,
    output logic                             s_awready,
    input  wire logic [31:0]                 s_wdata,
    input  wire logic [3:0]                  s_wstrb,
    input  wire logic                        s_wvalid,
    output logic                             s_wready,
    output logic [1:0]                       s_bresp,
    output logic                             s_bvalid,
    input  wire logic                        s_bready,
    input  wire logic [7:0]                  s_araddr,
    input  wire logic                        s_arvalid,
    output logic                             s_arready,
    output logic [31:0]                      s_rdata,
    output logic [1:0]                       s_rresp,
    output logic                             s_rvalid,
    input  wire logic                        s_rready
);
    import parity_chk_pkg::*;

    // ************************************************************
    // Registers and state
    // ************************************************************
    logic [31:0]         aux_ctrl;
    logic [2:0]          rd_lat;
    logic                raw_perr;
    logic                int_mask;
    logic [15:0]         err_count;
    rd_state_t           rd_state;
    logic [2:0]          wait_cnt;
    logic                check_now;
    logic                lane_err;
    logic                perr_event;
    logic                parity_en;
    logic [7:0]          aw_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                aw_held;
    logic                w_held;
    logic                do_write;
    logic                clr_perr;

    // Byte-lane parity of the word compared against stored bits
    function automatic logic lanes_mismatch(
        input logic [WORD_W-1:0] word,
        input logic [PAR_W-1:0]  par
    );
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < PAR_W; i++) begin
            bad = bad | ((^word[i*8 +: 8]) != par[i]); // RQ8
        end
        return bad;
    endfunction

    function automatic logic [31:0] strb_merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // First state after a request with nonzero latency
    function automatic rd_state_t lat_entry(input logic [2:0] lat);
        return (lat == 3'h1) ? RD_CHECK : RD_WAIT;
    endfunction

    assign parity_en = aux_ctrl[PARITY_EN_BIT];

    // ************************************************************
    // Read timing: compare only in the data-valid cycle
    // ************************************************************
    // The check fires once per read accepted in RD_IDLE or RD_CHECK, rd_lat
    // cycles after the request; a request in RD_WAIT is dropped. The cycle before
    // the check is never examined because the RAM outputs may still be settling then.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= RD_IDLE;
            wait_cnt <= 3'h0;
        end else if (clk_en) begin
            case (rd_state)
                RD_IDLE: begin
                    if (ram_rd.rd_req && rd_lat != 3'h0) begin
                        rd_state <= lat_entry(rd_lat); // RQ5
                        wait_cnt <= rd_lat - 3'h1;
                    end
                end
                RD_WAIT: begin
                    if (wait_cnt == 3'h1) begin
                        rd_state <= RD_CHECK; // RQ6
                    end else begin
                        wait_cnt <= wait_cnt - 3'h1;
                    end
                end
                RD_CHECK: begin
                    if (ram_rd.rd_req && rd_lat != 3'h0) begin
                        rd_state <= lat_entry(rd_lat);
                        wait_cnt <= rd_lat - 3'h1;
                    end else begin
                        rd_state <= RD_IDLE;
                    end
                end
                default: rd_state <= RD_IDLE;
            endcase
        end
    end

    // Zero latency: data valid in the request cycle itself
    assign check_now = (rd_lat == 3'h0) ? ram_rd.rd_req
                                        : (rd_state == RD_CHECK); // RQ6
    assign lane_err  = lanes_mismatch(ram_rd.data_ram_read_word,
                                      ram_rd.stored_parity_word); // RQ1
    assign perr_event = clk_en && parity_en && check_now && lane_err; // RQ3

    // ************************************************************
    // Interrupt status
    // ************************************************************
    // A new error in the clearing cycle keeps the bit set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_perr <= 1'b0;
        end else if (perr_event) begin
            raw_perr <= 1'b1; // RQ2
        end else if (clr_perr) begin
            raw_perr <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_count <= 16'h0000;
        end else if (perr_event && err_count != 16'hFFFF) begin
            err_count <= err_count + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq               <= 1'b0;
            parity_fail_flags <= 8'h00;
        end else if (clk_en) begin
            irq <= (raw_perr | perr_event) & int_mask;
            parity_fail_flags[FAIL_LSB +: 2] <= {2{perr_event}}; // RQ7
        end
    end

    // ************************************************************
    // AXI4-Lite write path
    // ************************************************************
    assign do_write = aw_held && w_held && !s_bvalid;
    assign clr_perr = clk_en && do_write && aw_addr == INT_CLEAR_OFS
                      && w_strb[0] && w_data[PERR_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= 8'h00;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
        end else if (clk_en) begin
            s_awready <= !aw_held && !s_awready && s_awvalid;
            s_wready  <= !w_held && !s_wready && s_wvalid;
            if (s_awvalid && s_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (do_write) begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                s_bvalid <= 1'b1;
                case (aw_addr)
                    AUX_CTRL_OFS, LAT_CTRL_OFS, INT_MASK_OFS,
                    INT_CLEAR_OFS: s_bresp <= RESP_OKAY;
                    default:       s_bresp <= RESP_SLVERR;
                endcase
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_ctrl <= AUX_CTRL_RST; // RQ4
            rd_lat   <= RD_LAT_RST;
            int_mask <= INT_MASK_RST;
        end else if (clk_en && do_write) begin
            case (aw_addr)
                AUX_CTRL_OFS: aux_ctrl <= strb_merge(aux_ctrl, w_data,
                                                     w_strb);
                LAT_CTRL_OFS: if (w_strb[0]) begin
                    rd_lat <= w_data[RD_LAT_LSB +: RD_LAT_W]; // RQ5
                end
                INT_MASK_OFS: if (w_strb[0]) begin
                    int_mask <= w_data[PERR_BIT];
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // AXI4-Lite read path
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            s_arready <= !s_rvalid && !s_arready && s_arvalid;
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp  <= RESP_OKAY;
                s_rdata  <= 32'h0000_0000;
                case (s_araddr)
                    AUX_CTRL_OFS:   s_rdata <= aux_ctrl;
                    LAT_CTRL_OFS:   s_rdata[RD_LAT_LSB +: RD_LAT_W] <= rd_lat;
                    RAW_INT_OFS:    s_rdata[PERR_BIT] <= raw_perr; // RQ2
                    MASKED_INT_OFS: s_rdata[PERR_BIT] <= raw_perr & int_mask;
                    INT_MASK_OFS:   s_rdata[PERR_BIT] <= int_mask;
                    INT_CLEAR_OFS:  ;
                    ERR_COUNT_OFS:  s_rdata[15:0] <= err_count;
                    default:        s_rresp <= RESP_SLVERR;
                endcase
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_CHECK_CAUSES_FLAG: assert property ( // RQ2
        @(posedge aclk) disable iff (!aresetn)
        perr_event |=> raw_perr)
        else $error("parity error did not set raw status");
    AST_FAIL_PAIR: assert property ( // RQ7
        @(posedge aclk) disable iff (!aresetn)
        perr_event |=> parity_fail_flags[7:6] == 2'h3)
        else $error("fail outputs not raised on error");
    AST_NO_FAIL_WHEN_OFF: assert property ( // RQ3
        @(posedge aclk) disable iff (!aresetn)
        clk_en && !parity_en |=> parity_fail_flags[7:6] == 2'h0)
        else $error("fail output while parity disabled");
    AST_RESET_DISABLED: assert property ( // RQ4
        @(posedge aclk)
        !aresetn |=> !aux_ctrl[PARITY_EN_BIT])
        else $error("parity enable not clear after reset");
    AST_LAT1_TIMING: assert property ( // RQ5
        @(posedge aclk) disable iff (!aresetn)
        clk_en && rd_state == RD_IDLE && ram_rd.rd_req && rd_lat == 3'h1
        |=> check_now)
        else $error("latency one check not one cycle after request");
    AST_ONE_CYCLE_CHECK: assert property ( // RQ6
        @(posedge aclk) disable iff (!aresetn)
        rd_lat != 3'h0 && clk_en && rd_state == RD_WAIT |-> !check_now)
        else $error("compare during unstable cycle");
    // Odd total parity over all lanes means at least one lane is wrong
    AST_LANE_MISMATCH: assert property ( // RQ8
        @(posedge aclk) disable iff (!aresetn)
        (^ram_rd.data_ram_read_word) != (^ram_rd.stored_parity_word)
        |-> lane_err)
        else $error("lane mismatch missed");
    AST_CHECK_ON_READ: assert property ( // RQ1
        @(posedge aclk) disable iff (!aresetn)
        clk_en && parity_en && check_now && lane_err
        && err_count != 16'hFFFF
        |=> err_count == $past(err_count) + 16'h0001)
        else $error("checked read error not counted");
    AST_IRQ_MASKED: assert property ( // RQ2
        @(posedge aclk) disable iff (!aresetn)
        clk_en && !int_mask |=> !irq)
        else $error("irq raised while masked");
    COV_ERR: cover property (@(posedge aclk) perr_event);
    COV_LAT_CHECK: cover property (@(posedge aclk)
        rd_state == RD_CHECK && lane_err && parity_en);
    COV_CLEAR: cover property (@(posedge aclk) raw_perr ##1 clr_perr);
    COV_IRQ: cover property (@(posedge aclk) irq);

endmodule

// File: tb/data_ram_model.sv
// Behavioural data RAM and parity RAM answering the checker's reads
`timescale 1ns/1ns
module data_ram_model (
    // Clock
    input  wire logic                aclk,
    // Control from the bench
    input  wire logic                req,
    input  wire logic [2:0]          lat,
    input  wire logic                bad,
    input  wire logic [4:0]          lane,
    // Read port toward the checker
    output parity_chk_pkg::ram_read_t ram_rd
);
    import parity_chk_pkg::*;

    logic [WORD_W-1:0] word;
    logic [PAR_W-1:0]  good_par;
    logic [2:0]        left = 3'h0;
    logic              valid;

    // ************************************************************
    // Read timing
    // ************************************************************
    always_comb begin
        for (int i = 0; i < PAR_W; i++) begin
            good_par[i] = ^word[8*i +: 8];
        end
    end

    assign valid = (req && lat == 3'h0) || (left == 3'h1);

    always_ff @(posedge aclk) begin
        word <= {8{$urandom}};
        if (req && lat != 3'h0) begin
            left <= lat;
        end else if (left != 3'h0) begin
            left <= left - 3'h1;
        end
    end

    // Off the valid cycle every lane is wrong, so an early check shows up
    always_comb begin
        ram_rd.rd_req             = req;
        ram_rd.data_ram_read_word = word;
        if (!valid) begin
            ram_rd.stored_parity_word = ~good_par;
        end else if (bad) begin
            ram_rd.stored_parity_word = good_par ^ (32'h1 << lane);
        end else begin
            ram_rd.stored_parity_word = good_par;
        end
    end
endmodule

// File: tb/tb_l2_data_ram_parity_checker.sv
// Self-checking bench for the data RAM parity checker
`timescale 1ns/1ns
`define CHK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("unexpected %s expected %h seen %h", what, exp, got); \
        end \
    end
module tb_l2_data_ram_parity_checker;
    import parity_chk_pkg::*;

    logic              aclk, aresetn, clk_en, irq;
    ram_read_t         ram_rd;
    logic [7:0]        parity_fail_flags, s_awaddr, s_araddr;
    logic              s_awvalid, s_awready, s_wvalid, s_wready;
    logic              s_bvalid, s_bready, s_arvalid, s_arready;
    logic              s_rvalid, s_rready, req, bad;
    logic [31:0]       s_wdata, s_rdata;
    logic [3:0]        s_wstrb;
    logic [1:0]        s_bresp, s_rresp;
    logic [2:0]        lat;
    logic [4:0]        lane;
    int                fails = 0;
    int                compares = 0;

    l2_data_ram_parity_checker l2_data_ram_parity_checker_i (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .ram_rd(ram_rd),
        .parity_fail_flags(parity_fail_flags), .irq(irq),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready));

    data_ram_model data_ram_model_i (
        .aclk(aclk), .req(req), .lat(lat), .bad(bad), .lane(lane),
        .ram_rd(ram_rd));

    // ************************************************************
    // Bus tasks and verdict
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        `CHK("write response", er, s_bresp)
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        @(posedge aclk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        s_rready <= 1'b0;
        `CHK("read response", er, s_rresp)
        if (er === RESP_OKAY) `CHK("read data", ed, s_rdata)
    endtask

    // One read request, then count fail pulses over n cycles
    task automatic probe(input int n, output int hits, output int odd);
        hits = 0;
        odd  = 0;
        @(posedge aclk);
        req <= 1'b1;
        @(posedge aclk);
        req <= 1'b0;
        repeat (n) begin
            @(posedge aclk);
            if (parity_fail_flags === 8'hC0) hits++;
            else if (parity_fail_flags !== 8'h00) odd++;
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Whole run is near 1400 cycles; this cuts a hang well past that
    initial begin
        #200000;
        fails++;
        end_of_test();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        int hits, odd, errs, m, raw;
        void'($urandom(477));
        {aresetn, req, bad, lat, lane} = '0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        s_wstrb = 4'hF;
        clk_en = 1'b1;
        errs = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk_rd(AUX_CTRL_OFS, 32'h0, RESP_OKAY);
        chk_rd(LAT_CTRL_OFS, 32'h0, RESP_OKAY);
        chk_rd(INT_MASK_OFS, 32'h0, RESP_OKAY);
        chk_rd(8'h1C, 32'h0, RESP_SLVERR);
        wr(RAW_INT_OFS, 32'h1, RESP_SLVERR);
        wr(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
        for (int e = 0; e < 2; e++) begin
            for (int l = 0; l < 8; l++) begin
                for (int b = 0; b < 2; b++) begin
                    m = $urandom_range(1, 0);
                    raw = e & b;
                    errs += raw;
                    wr(AUX_CTRL_OFS, 32'(e) << PARITY_EN_BIT, RESP_OKAY);
                    wr(LAT_CTRL_OFS, 32'(l) << RD_LAT_LSB, RESP_OKAY);
                    wr(INT_MASK_OFS, 32'(m), RESP_OKAY);
                    lat  <= 3'(l);
                    bad  <= 1'(b);
                    lane <= 5'($urandom_range(31, 0));
                    probe(l + 4, hits, odd);
                    `CHK("fail pulses", raw, hits)
                    `CHK("stray flags", 0, odd)
                    `CHK("irq set", 1'(m & raw), irq)
                    chk_rd(RAW_INT_OFS, 32'(raw), RESP_OKAY);
                    chk_rd(MASKED_INT_OFS, 32'(m & raw), RESP_OKAY);
                    wr(INT_CLEAR_OFS, 32'h1, RESP_OKAY);
                    chk_rd(RAW_INT_OFS, 32'h0, RESP_OKAY);
                    `CHK("irq clear", 1'b0, irq)
                end
            end
        end
        chk_rd(ERR_COUNT_OFS, 32'(errs), RESP_OKAY);
        // A frozen block ignores a bad read; a live one reports it
        wr(AUX_CTRL_OFS, 32'h1 << PARITY_EN_BIT, RESP_OKAY);
        wr(LAT_CTRL_OFS, 32'h0, RESP_OKAY);
        wr(INT_MASK_OFS, 32'h1, RESP_OKAY);
        lat    <= 3'h0;
        bad    <= 1'b1;
        clk_en <= 1'b0;
        probe(3, hits, odd);
        `CHK("frozen pulses", 0, hits + odd)
        clk_en <= 1'b1;
        probe(3, hits, odd);
        `CHK("live pulses", 1, hits)
        `CHK("live stray", 0, odd)
        `CHK("irq live", 1'b1, irq)
        // Reset in mid-run must drop enable and status again
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk_rd(AUX_CTRL_OFS, 32'h0, RESP_OKAY);
        chk_rd(RAW_INT_OFS, 32'h0, RESP_OKAY);
        `CHK("irq reset", 1'b0, irq)
        end_of_test();
    end
endmodule
